// ==== src/timer_mts_pkg.sv ====
// constants, field layouts and carrier types of the master trigger select
// assumes a 16-bit register port with byte addresses on eight bits
package timer_mts_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int NCHAN = 4;

	// register offsets
	localparam logic [7:0] OFF_CTRL_ONE = 8'h00;
	localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
	localparam logic [7:0] OFF_SLAVE_CFG = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFF_EVENT_GEN = 8'h14;

	// first control register fields
	localparam int RUN_BIT_POS = 0;
	localparam int BLOCK_BIT_POS = 1;
	// event generation register field
	localparam int FORCE_UPD_POS = 0;
	// slave configuration fields
	localparam int GATED_POS = 0;
	localparam int SYNC_POS = 1;
	// second control register fields
	localparam int TI1_SEL_POS = 7;
	localparam int MODE_LSB = 4;
	localparam int DMA_SEL_POS = 3;
	// interrupt status fields
	localparam int IRQ_UPD_POS = 0;
	localparam int IRQ_TRIG_POS = 1;
	localparam int IRQ_DMA_POS = 2;
	localparam int IRQ_W = 3;

	// reset values
	localparam logic [DATA_W-1:0] CTRL_TWO_RST = 16'h0000;
	localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

	// selections of the trigger output
	typedef enum logic [2:0] {
		MODE_RESET = 3'h0,
		MODE_ENABLE = 3'h1,
		MODE_UPDATE = 3'h2,
		MODE_CAPCMP = 3'h3,
		MODE_CMP1 = 3'h4,
		MODE_CMP2 = 3'h5,
		MODE_CMP3 = 3'h6,
		MODE_CMP4 = 3'h7
	} master_mode_t;

	// second control register layout
	typedef struct packed {
		logic [7:0] rsv_hi;
		logic ti1_sel;
		master_mode_t master_trigger_select;
		logic chan_dma_source_sel;
		logic [2:0] rsv_lo;
	} ctrl_two_t;

	// per-channel signals from the channel logic
	typedef struct packed {
		logic [NCHAN-1:0] channel_capture_compare;
		logic [NCHAN-1:0] compare_ref;
	} chan_sig_t;

endpackage

// ==== src/sync2.sv ====
// two flip-flop synchroniser for one level
// assumes the input comes from another clock domain or a pin
`timescale 1ns/1ps
module sync2 (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_d,
	output logic o_q
);

	logic meta_q;

	// first stage feeds only the second
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_q <= 1'b0;
			o_q <= 1'b0;
		end else begin
			meta_q <= i_d;
			o_q <= meta_q;
		end
	end

endmodule // sync2

// ==== src/timer_master_trigger_select.sv ====
// master trigger output select and channel dma request source of a timer
// assumes counter core and channel logic run on i_clk; trigger input
// arrives from another timer or a pin and is synchronised here
//
// How it works
// R1 - mode 000: writing the force update bit gives one trigger pulse
// R2 - mode 001: trigger output follows the counter run signal
// R3 - counter run signal is run bit OR trigger input in gated mode
// R4 - gated trigger reaches the output one cycle late unless sync mode
// R5 - mode 010: each update event appears on the trigger output
// R6 - mode 011: a rise of the OR of all channel capture or compare signals gives a positive pulse
// R7 - modes 100 and 101: output follows channel 1 or 2 compare reference
// R8 - modes 110 and 111: output follows channel 3 or 4 compare reference
// R9 - dma source select 0: channel dma request on channel event
// R10 - dma source select 1: all channel dma requests on update event
// R11 - software keeps reserved bits 2 to 0 at reset value
// R12 - update block stops update events; force update still reinitialises
// R13 - pulses of modes 000 and 011 last one clock cycle
`timescale 1ns/1ps
module timer_master_trigger_select (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic [timer_mts_pkg::ADDR_W-1:0] i_addr,
	input wire logic [timer_mts_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [timer_mts_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_trig_in,
	input wire logic i_counter_wrap,
	input wire timer_mts_pkg::chan_sig_t i_chan,
	output logic o_master_trigger_out,
	output logic o_counter_run_signal,
	output logic o_update_event,
	output logic o_counter_reinit,
	output logic [timer_mts_pkg::NCHAN-1:0] o_cc_dma_req,
	output logic o_irq
);
	import timer_mts_pkg::*;

	ctrl_two_t ctrl_two_q;
	logic counter_run_bit_q;
	logic update_block_bit_q;
	logic gated_q;
	logic sync_mode_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_set;
	logic [DATA_W-1:0] rdata_d;
	logic [DATA_W-1:0] rdata_q;
	logic trig_s;
	logic force_update_bit;
	logic counter_run_signal;
	logic run_dly_q;
	logic enable_src;
	logic upd;
	logic any_cc;
	logic any_cc_q;
	logic cc_pulse;
	logic trig_d;
	logic trig_q;
	logic trig_prev_q;
	logic upd_q;
	logic reinit_q;
	logic run_q;
	logic [NCHAN-1:0] dma_q;
	master_mode_t mode;

	// address match for a given register offset
	function automatic logic hit(input logic [ADDR_W-1:0] a,
			input logic [7:0] off);
		hit = (a == off);
	endfunction

	// trigger input enters the clock domain
	sync2 u_trig_sync (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_d(i_trig_in),
		.o_q(trig_s)
	);

	assign mode = ctrl_two_q.master_trigger_select;

	// first control register: run and update block bits
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			counter_run_bit_q <= 1'b0;
			update_block_bit_q <= 1'b0;
		end else if (i_wr && hit(i_addr, OFF_CTRL_ONE)) begin
			counter_run_bit_q <= i_wdata[RUN_BIT_POS];
			update_block_bit_q <= i_wdata[BLOCK_BIT_POS];
		end
	end

	// second control register, reserved bits stored as zero
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_two_q <= ctrl_two_t'(CTRL_TWO_RST);
		end else if (i_wr && hit(i_addr, OFF_CTRL_TWO)) begin
			ctrl_two_q.rsv_hi <= 8'h00;
			ctrl_two_q.ti1_sel <= i_wdata[TI1_SEL_POS];
			ctrl_two_q.master_trigger_select <=
				master_mode_t'(i_wdata[MODE_LSB +: 3]);
			ctrl_two_q.chan_dma_source_sel <= i_wdata[DMA_SEL_POS];
			// R11 reserved low bits ignored
			ctrl_two_q.rsv_lo <= 3'h0;
		end
	end

	// slave configuration: gated mode and master/slave sync
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			gated_q <= 1'b0;
			sync_mode_q <= 1'b0;
		end else if (i_wr && hit(i_addr, OFF_SLAVE_CFG)) begin
			gated_q <= i_wdata[GATED_POS];
			sync_mode_q <= i_wdata[SYNC_POS];
		end
	end

	// force update is a write of one to the event generation register
	assign force_update_bit = i_wr && hit(i_addr, OFF_EVENT_GEN) &&
		i_wdata[FORCE_UPD_POS];

	// R3 run signal from run bit or gated trigger
	assign counter_run_signal = counter_run_bit_q | (gated_q & trig_s);

	// R4 delayed copy when the trigger drives the run signal
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			run_dly_q <= 1'b0;
		end else begin
			run_dly_q <= counter_run_signal;
		end
	end

	// R4 sync mode takes the undelayed run signal
	assign enable_src = (gated_q && !sync_mode_q) ? run_dly_q :
		counter_run_signal;

	// R12 update event suppressed while blocked
	assign upd = (i_counter_wrap | force_update_bit) & ~update_block_bit_q;

	// R13 capture/compare pulse taken on the rising edge only
	assign any_cc = |i_chan.channel_capture_compare;
	assign cc_pulse = any_cc & ~any_cc_q;

	// source of the trigger output for the selected mode
	always_comb begin
		trig_d = 1'b0;
		case (mode)
			// R1 force update pulse
			MODE_RESET: trig_d = force_update_bit;
			// R2 counter run signal
			MODE_ENABLE: trig_d = enable_src;
			// R5 update event
			MODE_UPDATE: trig_d = upd;
			// R6 capture or compare pulse
			MODE_CAPCMP: trig_d = cc_pulse;
			// R7 channel 1 and 2 references
			MODE_CMP1: trig_d = i_chan.compare_ref[0];
			MODE_CMP2: trig_d = i_chan.compare_ref[1];
			// R8 channel 3 and 4 references
			MODE_CMP3: trig_d = i_chan.compare_ref[2];
			MODE_CMP4: trig_d = i_chan.compare_ref[3];
			default: trig_d = 1'b0;
		endcase
	end

	// trigger output and its edge history
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			trig_q <= 1'b0;
			trig_prev_q <= 1'b0;
			any_cc_q <= 1'b0;
		end else begin
			trig_q <= trig_d;
			trig_prev_q <= trig_q;
			any_cc_q <= any_cc;
		end
	end

	// R12 counter reinit on force update even while blocked
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			upd_q <= 1'b0;
			reinit_q <= 1'b0;
			run_q <= 1'b0;
		end else begin
			upd_q <= upd;
			reinit_q <= force_update_bit;
			run_q <= counter_run_signal;
		end
	end

	// R9 R10 channel dma request source
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			dma_q <= '0;
		end else if (ctrl_two_q.chan_dma_source_sel) begin
			dma_q <= {NCHAN{upd}};
		end else begin
			dma_q <= i_chan.channel_capture_compare;
		end
	end

	// interrupt events: update, trigger rise, any dma request
	assign irq_set[IRQ_UPD_POS] = upd_q;
	assign irq_set[IRQ_TRIG_POS] = trig_q & ~trig_prev_q;
	assign irq_set[IRQ_DMA_POS] = |dma_q;

	// sticky status, write one clears, a new event wins
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_stat_q <= IRQ_RST;
		end else if (i_wr && hit(i_addr, OFF_IRQ_STAT)) begin
			irq_stat_q <= (irq_stat_q & ~i_wdata[IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_q <= irq_stat_q | irq_set;
		end
	end

	// interrupt mask
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_mask_q <= IRQ_RST;
		end else if (i_wr && hit(i_addr, OFF_IRQ_MASK)) begin
			irq_mask_q <= i_wdata[IRQ_W-1:0];
		end
	end

	// read decode, unmapped reads return zero
	always_comb begin
		rdata_d = '0;
		if (hit(i_addr, OFF_CTRL_ONE)) begin
			rdata_d[RUN_BIT_POS] = counter_run_bit_q;
			rdata_d[BLOCK_BIT_POS] = update_block_bit_q;
		end else if (hit(i_addr, OFF_CTRL_TWO)) begin
			rdata_d = DATA_W'(ctrl_two_q);
		end else if (hit(i_addr, OFF_SLAVE_CFG)) begin
			rdata_d[GATED_POS] = gated_q;
			rdata_d[SYNC_POS] = sync_mode_q;
		end else if (hit(i_addr, OFF_IRQ_MASK)) begin
			rdata_d[IRQ_W-1:0] = irq_mask_q;
		end else if (hit(i_addr, OFF_IRQ_STAT)) begin
			rdata_d[IRQ_W-1:0] = irq_stat_q;
		end else begin
			rdata_d = '0;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rdata_q <= '0;
		end else if (i_rd) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= '0;
		end
	end

	assign o_rdata = rdata_q;
	assign o_master_trigger_out = trig_q;
	assign o_counter_run_signal = run_q;
	assign o_update_event = upd_q;
	assign o_counter_reinit = reinit_q;
	assign o_cc_dma_req = dma_q;
	assign o_irq = |(irq_stat_q & irq_mask_q);

	// checks on the trigger, run signal, update event, reinit and dma paths
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);

	property p_reset_pulse;
		(mode == MODE_RESET && force_update_bit) |=> o_master_trigger_out;
	endproperty
	a_reset_pulse: assert property (p_reset_pulse) // R1
		else $error("force update gave no trigger pulse");

	property p_pulse_width;
		(mode == MODE_RESET && o_master_trigger_out && !force_update_bit)
			|=> !o_master_trigger_out;
	endproperty
	a_pulse_width: assert property (p_pulse_width) // R13
		else $error("reset mode pulse longer than one cycle");

	property p_enable;
		(mode == MODE_ENABLE) |=> (o_master_trigger_out == $past(enable_src));
	endproperty
	a_enable: assert property (p_enable) // R2
		else $error("trigger output does not follow run signal");

	property p_run;
		counter_run_bit_q |=> o_counter_run_signal;
	endproperty
	a_run: assert property (p_run) // R3
		else $error("run bit did not raise run signal");

	property p_delay;
		(mode == MODE_ENABLE && gated_q && !sync_mode_q && !counter_run_bit_q
			&& $rose(trig_s)) |=> !o_master_trigger_out ##1
			o_master_trigger_out;
	endproperty
	a_delay: assert property (p_delay) // R4
		else $error("gated trigger not delayed by one cycle");

	property p_update;
		(mode == MODE_UPDATE) |=> (o_master_trigger_out == $past(upd));
	endproperty
	a_update: assert property (p_update) // R5
		else $error("update event missing on trigger output");

	property p_capcmp;
		(mode == MODE_CAPCMP && any_cc && !any_cc_q) |=> o_master_trigger_out;
	endproperty
	a_capcmp: assert property (p_capcmp) // R6
		else $error("capture or compare gave no pulse");

	property p_ref12;
		(mode == MODE_CMP1 || mode == MODE_CMP2) |=> (o_master_trigger_out
			== $past(i_chan.compare_ref[{1'b0, mode[0]}]));
	endproperty
	a_ref12: assert property (p_ref12) // R7
		else $error("trigger output not channel 1 or 2 reference");

	property p_ref34;
		(mode == MODE_CMP3 || mode == MODE_CMP4) |=> (o_master_trigger_out
			== $past(i_chan.compare_ref[{1'b1, mode[0]}]));
	endproperty
	a_ref34: assert property (p_ref34) // R8
		else $error("trigger output not channel 3 or 4 reference");

	property p_dma_chan;
		!ctrl_two_q.chan_dma_source_sel |=>
			(o_cc_dma_req == $past(i_chan.channel_capture_compare));
	endproperty
	a_dma_chan: assert property (p_dma_chan) // R9
		else $error("dma request not from channel event");

	property p_dma_upd;
		(ctrl_two_q.chan_dma_source_sel && upd) |=> (o_cc_dma_req == 4'hF);
	endproperty
	a_dma_upd: assert property (p_dma_upd) // R10
		else $error("dma request not raised on update");

	property p_block;
		update_block_bit_q |=> !o_update_event;
	endproperty
	a_block: assert property (p_block) // R12
		else $error("update event while blocked");

	property p_reinit;
		force_update_bit |=> o_counter_reinit;
	endproperty
	a_reinit: assert property (p_reinit) // R12
		else $error("force update did not reinitialise");

	// main scenarios
	c_reset_pulse: cover property (mode == MODE_RESET && force_update_bit
		##1 o_master_trigger_out);
	c_gated: cover property (gated_q && !sync_mode_q && $rose(trig_s)
		##2 o_master_trigger_out);
	c_dma_upd: cover property (ctrl_two_q.chan_dma_source_sel
		&& upd ##1 o_cc_dma_req == 4'hF);
	c_irq: cover property ($rose(o_irq));

endmodule // timer_master_trigger_select

// ==== verif/slave_timer_model.sv ====
// slave timer that listens to the master trigger output
// assumes the trigger is synchronous to the master's clock
`timescale 1ns/1ps
module slave_timer_model (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_trig,
	input wire logic i_clr,
	output logic [15:0] o_starts
);
	logic trig_q;

	// count starts, one for each rising edge of the trigger
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			trig_q <= 1'h0;
			o_starts <= 16'h0000;
		end else begin
			trig_q <= i_trig;
			if (i_clr)
				o_starts <= 16'h0000;
			else if (i_trig && !trig_q)
				o_starts <= o_starts + 16'h0001;
		end
	end
endmodule // slave_timer_model

// ==== verif/timer_master_trigger_select_tb.sv ====
// self-checking bench of the master trigger select
// assumes a slave timer model on the trigger output
`timescale 1ns/1ps
module timer_master_trigger_select_tb;
	import timer_mts_pkg::*;
	typedef struct {int sel; logic [15:0] v;} note_t;
	logic i_clk, i_arst_n, i_wr, i_rd, i_trig_in, i_counter_wrap, clr;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata, o_rdata;
	chan_sig_t i_chan;
	logic o_master_trigger_out, o_counter_run_signal, o_update_event;
	logic o_counter_reinit, o_irq;
	logic [NCHAN-1:0] o_cc_dma_req;
	logic [15:0] starts;
	logic [31:0] seed;
	note_t exp_q[$];
	int error_cnt, checks_done;
	string nm[8] = '{"rdata", "trigger", "update", "reinit", "dma", "irq",
		"starts", "run"};

	timer_master_trigger_select i_dut (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rdata(o_rdata),
		.i_trig_in(i_trig_in),
		.i_counter_wrap(i_counter_wrap),
		.i_chan(i_chan),
		.o_master_trigger_out(o_master_trigger_out),
		.o_counter_run_signal(o_counter_run_signal),
		.o_update_event(o_update_event),
		.o_counter_reinit(o_counter_reinit),
		.o_cc_dma_req(o_cc_dma_req),
		.o_irq(o_irq)
	);

	slave_timer_model i_slave (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_trig(o_master_trigger_out),
		.i_clr(clr),
		.o_starts(starts)
	);

	// clock
	initial begin
		i_clk = 1'h0;
		forever #12.5 i_clk = ~i_clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction

	// one bus cycle, strobe left up for the next call to change
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [15:0] d);
		i_wr <= w;
		i_rd <= !w;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
	endtask

	task automatic idle(input int n);
		i_wr <= 1'h0;
		i_rd <= 1'h0;
		repeat (n) @(posedge i_clk);
	endtask

	task automatic chk(input int s, input logic [15:0] v);
		exp_q.push_back('{s, v});
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus(1'h1, a, d);
	endtask

	// read data stand in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [15:0] v);
		bus(1'h0, a, 16'h0000);
		chk(0, v);
	endtask

	task automatic tend(input string s);
		$display("test %s done", s);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// compare every pending note against the settled outputs
	always @(negedge i_clk) begin
		logic [15:0] seen;
		note_t n;
		while (exp_q.size() > 0) begin
			n = exp_q.pop_front();
			case (n.sel)
				0: seen = o_rdata;
				1: seen = 16'(o_master_trigger_out);
				2: seen = 16'(o_update_event);
				3: seen = 16'(o_counter_reinit);
				4: seen = 16'(o_cc_dma_req);
				5: seen = 16'(o_irq);
				6: seen = starts;
				default: seen = 16'(o_counter_run_signal);
			endcase
			checks_done++;
			if (seen !== n.v) begin
				error_cnt++;
				$display("wrong value %s expected %h seen %h", nm[n.sel], n.v,
					seen);
			end
		end
	end

	// force update, blocked or not
	task automatic pulse_upd(input logic blk);
		wr(OFF_CTRL_ONE, {14'h0, blk, 1'h0});
		wr(OFF_EVENT_GEN, 16'h0001);
		chk(1, 16'h0001);
		chk(3, 16'h0001);
		chk(2, {15'h0, !blk});
		idle(1);
		chk(1, 16'h0000);
	endtask

	// watchdog
	initial begin
		repeat (2000) @(posedge i_clk);
		error_cnt++;
		wrap_up();
	end

	initial begin
		i_arst_n = 1'h0;
		i_wr = 1'h0;
		i_rd = 1'h0;
		i_addr = 8'h00;
		i_wdata = 16'h0000;
		i_trig_in = 1'h0;
		i_counter_wrap = 1'h0;
		i_chan = '0;
		clr = 1'h0;
		seed = 32'hFA7B;
		repeat (2) @(posedge i_clk);
		i_arst_n <= 1'h1;
		idle(1);
		rd(OFF_CTRL_TWO, CTRL_TWO_RST);
		rd(8'h20, 16'h0000);
		wr(8'h20, 16'hFFFF);
		rd(8'h20, 16'h0000);
		seed = xs(seed);
		wr(OFF_CTRL_TWO, seed[15:0] & 16'h00F8);
		rd(OFF_CTRL_TWO, seed[15:0] & 16'h00F8);
		rd(OFF_EVENT_GEN, 16'h0000);
		tend("registers");
		wr(OFF_CTRL_TWO, 16'h0000);
		clr <= 1'h1;
		idle(1);
		clr <= 1'h0;
		pulse_upd(1'h0);
		pulse_upd(1'h1);
		idle(2);
		chk(6, 16'h0002);
		tend("reset mode");
		wr(OFF_CTRL_TWO, 16'h0020);
		for (int b = 0; b < 2; b++) begin
			wr(OFF_CTRL_ONE, 16'(b * 2));
			idle(1);
			i_counter_wrap <= 1'h1;
			idle(1);
			i_counter_wrap <= 1'h0;
			chk(1, 16'(1 - b));
			chk(2, 16'(1 - b));
		end
		tend("update mode");
		wr(OFF_CTRL_ONE, 16'h0000);
		wr(OFF_CTRL_TWO, 16'h0010);
		for (int s = 0; s < 2; s++) begin
			wr(OFF_SLAVE_CFG, 16'(1 + 2 * s));
			idle(3);
			i_trig_in <= 1'h1;
			repeat (3 - s) @(posedge i_clk);
			chk(1, 16'h0000);
			@(posedge i_clk);
			chk(1, 16'h0001);
			i_trig_in <= 1'h0;
			idle(6);
		end
		wr(OFF_SLAVE_CFG, 16'h0000);
		wr(OFF_CTRL_ONE, 16'h0001);
		idle(1);
		chk(1, 16'h0001);
		chk(7, 16'h0001);
		wr(OFF_CTRL_ONE, 16'h0000);
		idle(2);
		chk(1, 16'h0000);
		tend("enable mode");
		wr(OFF_CTRL_TWO, 16'h0030);
		clr <= 1'h1;
		idle(1);
		clr <= 1'h0;
		for (int c = 0; c < NCHAN; c++) begin
			i_chan.channel_capture_compare <= 4'(1 << c);
			@(posedge i_clk);
			chk(1, 16'h0001);
			chk(4, 16'(1 << c));
			if (c == 3) begin
				@(posedge i_clk);
				chk(1, 16'h0000);
			end
			i_chan.channel_capture_compare <= 4'h0;
			idle(2);
			chk(1, 16'h0000);
			chk(4, 16'h0000);
		end
		chk(6, 16'h0004);
		wr(OFF_CTRL_TWO, 16'h0038);
		idle(1);
		i_chan.channel_capture_compare <= 4'hF;
		@(posedge i_clk);
		i_chan.channel_capture_compare <= 4'h0;
		i_counter_wrap <= 1'h1;
		chk(4, 16'h0000);
		@(posedge i_clk);
		i_counter_wrap <= 1'h0;
		chk(4, 16'h000F);
		idle(2);
		tend("capture compare and dma");
		for (int m = 4; m < 8; m++) begin
			wr(OFF_CTRL_TWO, 16'(m << 4));
			for (int k = 0; k < 4; k++) begin
				seed = xs(seed);
				i_chan.compare_ref <= seed[3:0];
				idle(1);
				chk(1, 16'(seed[m - 4]));
			end
		end
		i_chan.compare_ref <= 4'h0;
		tend("compare modes");
		wr(OFF_CTRL_TWO, 16'h0000);
		wr(OFF_IRQ_STAT, 16'h0007);
		wr(OFF_IRQ_MASK, 16'h0007);
		rd(OFF_IRQ_STAT, 16'h0000);
		rd(OFF_IRQ_MASK, 16'h0007);
		wr(OFF_EVENT_GEN, 16'h0001);
		idle(1);
		chk(5, 16'h0001);
		rd(OFF_IRQ_STAT, 16'h0003);
		wr(OFF_IRQ_MASK, 16'h0000);
		idle(1);
		chk(5, 16'h0000);
		wr(OFF_IRQ_STAT, 16'h0003);
		rd(OFF_IRQ_STAT, 16'h0000);
		wr(OFF_IRQ_MASK, 16'h0007);
		idle(1);
		chk(5, 16'h0000);
		// channel event sets the dma status bit
		i_chan.channel_capture_compare <= 4'h2;
		@(posedge i_clk);
		chk(4, 16'h0002);
		i_chan.channel_capture_compare <= 4'h0;
		idle(1);
		chk(5, 16'h0001);
		rd(OFF_IRQ_STAT, 16'h0004);
		tend("interrupts");
		idle(3);
		wrap_up();
	end
endmodule // timer_master_trigger_select_tb
